// ---- shared/led_driver_pkg.sv ----
// Shared constants for the LED driver configuration and status latches.
package led_driver_pkg;

    localparam int NUM_COLORS = 3;
    localparam int OUTS_PER_COLOR = 8;
    localparam int NUM_OUTPUTS = 24;
    localparam int NUM_PAIRS = 4;

    localparam int GRAY_BITS = 12;
    localparam int GRAY_WORD = 288;
    localparam int CFG_BITS = 216;

    localparam int TRIM_BITS = 7;
    localparam int TRIM_LSB = 0;
    localparam int TRIM_MSB = 167;
    localparam int BRIGHT_BITS = 8;
    localparam int BRIGHT_LSB = 168;
    localparam int BRIGHT_MSB = 191;
    localparam int FUNC_BITS = 7;
    localparam int FUNC_LSB = 192;
    localparam int GRAY_CFG_MSB = 198;
    localparam int USER_BITS = 17;
    localparam int USER_LSB = 199;
    localparam int LEVEL_BITS = 15;

    // Field positions inside the function control bits.
    localparam int FUNC_RANGE_BIT = 0;
    localparam int FUNC_MODE_LSB = 1;
    localparam int FUNC_AUTO_BIT = 3;
    localparam int FUNC_TRESET_BIT = 4;

    localparam logic [1:0] MODE_12BIT = 2'h0;
    localparam logic [1:0] MODE_10BIT = 2'h1;
    localparam logic [1:0] MODE_8BIT = 2'h2;

    localparam logic [12:0] LIMIT_8BIT = 13'h0100;
    localparam logic [12:0] LIMIT_10BIT = 13'h0400;
    localparam logic [12:0] LIMIT_12BIT = 13'h1000;
    localparam logic [12:0] LAST_TICK = 13'h0fff;
    localparam logic [12:0] DETECT_TICK = 13'h0021;

    // Status word layout.
    localparam int STAT_OPEN_LSB = 0;
    localparam int STAT_SHORT_LSB = 24;
    localparam int STAT_THERMAL_BIT = 48;
    localparam int STAT_CFG_LSB = 72;

    // Trim latch delay window after the last trim shift edge.
    localparam int CLK_MHZ = 10;
    localparam int TRIM_LATCH_MIN_US = 3000;
    localparam int TRIM_LATCH_MAX_US = 7000;
    localparam int TRIM_LATCH_CYCLES = TRIM_LATCH_MIN_US * CLK_MHZ;

endpackage : led_driver_pkg

// ---- shared/pwm_group_if.sv ----
// Signals between the latch controller and one color group of outputs.
interface pwm_group_if;
    logic tick;
    logic blank;
    logic force_off;
    logic auto_repeat;
    logic [12:0] limit;
    logic [95:0] gray;
    logic [7:0] open_sense;
    logic [7:0] short_sense;
    logic [7:0] on;
    logic [7:0] open_flag;
    logic [7:0] short_flag;
    logic first_tick;

    modport ctrl (
        output tick, blank, force_off, auto_repeat, limit, gray,
        output open_sense, short_sense,
        input on, open_flag, short_flag, first_tick
    );

    modport group (
        input tick, blank, force_off, auto_repeat, limit, gray,
        input open_sense, short_sense,
        output on, open_flag, short_flag, first_tick
    );
endinterface : pwm_group_if

// ---- design/led_pwm_group.sv ----
// One color group: period counter, staggered outputs and fault capture.
module led_pwm_group (
    input wire logic i_clk,
    input wire logic i_rstn,
    pwm_group_if.group bus
);

    logic [12:0] cnt_reg;
    logic [7:0] on_reg;
    logic [7:0] open_reg;
    logic [7:0] short_reg;

    // Pair p lags pair 0 by p ticks so the four pairs never switch on together.
    function automatic logic pair_on(input logic [12:0] cnt,
                                     input logic [1:0] pair,
                                     input logic [11:0] gray,
                                     input logic [12:0] limit);
        logic [12:0] lag;
        lag = cnt - {11'h000, pair};
        return (cnt > {11'h000, pair}) && (lag <= {1'b0, gray})
            && (lag < limit); // RULE_10 RULE_11
    endfunction : pair_on

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            cnt_reg <= 13'h0000;
        else if (bus.blank)
            cnt_reg <= 13'h0000;
        else if (bus.tick)
        begin
            if (bus.auto_repeat && cnt_reg == led_driver_pkg::LAST_TICK)
                cnt_reg <= 13'h0000; // RULE_21
            else if (cnt_reg != led_driver_pkg::LIMIT_12BIT)
                cnt_reg <= cnt_reg + 13'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            on_reg <= 8'h00;
        else
        begin
            for (int n = 0; n < led_driver_pkg::OUTS_PER_COLOR; n++)
            begin
                on_reg[n] <= !bus.blank && !bus.force_off // RULE_03 RULE_19
                    && pair_on(cnt_reg, 2'(n % led_driver_pkg::NUM_PAIRS),
                        bus.gray[n * 12 +: 12], bus.limit); // RULE_22 RULE_25
            end
        end
    end

    // Outputs that are off at the capture tick report no fault.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            open_reg <= 8'h00;
            short_reg <= 8'h00;
        end
        else if (bus.tick && !bus.blank
                 && cnt_reg == led_driver_pkg::DETECT_TICK - 13'h0001)
        begin
            open_reg <= on_reg & bus.open_sense; // RULE_15 RULE_16 RULE_17
            short_reg <= on_reg & bus.short_sense; // RULE_15 RULE_16
        end
    end

    assign bus.on = on_reg;
    assign bus.open_flag = open_reg;
    assign bus.short_flag = short_reg;
    assign bus.first_tick = bus.tick && !bus.blank && cnt_reg == 13'h0000;

endmodule : led_pwm_group

// ---- design/led_driver_config_status_latches.sv ----
// Configuration latches, status readback and output control of the driver.
// Summary of operation
// (RULE_01) Trim latch loads 3 to 7 ms after shifting.
// (RULE_02) Controller loads trim before enabling outputs.
// (RULE_03) Blanking low forces every output off.
// (RULE_04) Brightness occupies bits 168 to 191.
// (RULE_05) Group brightness scales trimmed current of eight outputs.
// (RULE_06) Controller writes brightness before enabling outputs.
// (RULE_07) Seven function bits select range, width, repeat, reset.
// (RULE_08) Controller programs function bits before enabling outputs.
// (RULE_09) Grayscale latch stays 288 bits, 12 per output.
// (RULE_10) Eight-bit mode cuts outputs at tick 256.
// (RULE_11) Ten-bit mode cuts outputs at tick 1024.
// (RULE_12) Seventeen user bits, readable, without any effect.
// (RULE_13) Status word: faults, thermal flag, configuration copy.
// (RULE_14) Status loads after grayscale latch, shifts out serially.
// (RULE_15) Fault flags update at tick 33 after unblanking.
// (RULE_16) Only outputs on at tick 33 are checked.
// (RULE_17) Open flag set for open LED, maybe missed.
// (RULE_18) Thermal flag marks overheating with outputs shut off.
// (RULE_19) Thermal shutdown holds until next period after cooling.
// (RULE_20) Thermal flag clears on latch strobe after cooling.
// (RULE_21) Internal blank on strobe or tick 4096 when enabled.
// (RULE_22) Outputs switch in four staggered pairs per color.
// (RULE_23) Trim fills bits 0 to 167, seven per output.
// (RULE_24) Strobe high at last edge loads configuration.
// (RULE_25) Pairs are one grayscale tick apart.
// (RULE_26) Status bit layout is fixed by this design.
module led_driver_config_status_latches #(
    parameter int unsigned TRIM_LATCH_CYCLES =
        led_driver_pkg::TRIM_LATCH_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_gray_port_shift_clock,
    input wire logic i_gray_port_serial_in,
    input wire logic i_gray_latch_strobe,
    input wire logic i_trim_port_shift_clock,
    input wire logic i_trim_port_serial_in,
    input wire logic [2:0] i_color_pwm_clocks,
    input wire logic i_blank_n_input,
    input wire logic i_over_temp,
    input wire logic i_temp_recovered,
    input wire logic [23:0] i_open_sense,
    input wire logic [23:0] i_short_sense,
    output logic o_gray_port_serial_out,
    output logic [23:0] o_output_on,
    output logic [23:0] o_open_detect_flag,
    output logic [23:0] o_short_detect_flag,
    output logic o_thermal_error_flag,
    output logic [359:0] o_output_level,
    output logic o_trim_range,
    output logic [16:0] o_user_defined_bits
);

    localparam int SYNC_W = 57;
    localparam int PIN_TRIM_CLK = 0;
    localparam int PIN_TRIM_DATA = 1;
    localparam int PIN_STROBE = 2;
    localparam int PIN_BLANK_N = 3;
    localparam int PIN_OVER = 4;
    localparam int PIN_RECOVERED = 5;
    localparam int PIN_PWM_LSB = 6;
    localparam int PIN_OPEN_LSB = 9;
    localparam int PIN_SHORT_LSB = 33;
    localparam logic [23:0] TRIM_LOAD = 24'(TRIM_LATCH_CYCLES);

    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] sync3_reg;
    logic [SYNC_W-1:0] filt_reg;
    logic [SYNC_W-1:0] filt_next;
    logic [SYNC_W-1:0] rise;

    logic [287:0] common_shift_reg;
    logic strobe_at_edge_reg;
    logic load_sync1_reg;
    logic load_sync2_reg;
    logic load_ack_reg;

    logic [287:0] gray_latch_reg;
    logic [215:0] cfg_latch_reg;
    logic [215:0] trim_shift_reg;
    logic [23:0] trim_timer_reg;
    logic [287:0] status_reg;
    logic status_pending_reg;
    logic load_tgl_reg;
    logic int_blank_reg;
    logic thermal_flag_reg;
    logic thermal_off_reg;
    logic blank_seen_reg;
    logic [359:0] level_reg;

    logic strobe_rise;
    logic trim_rise;
    logic trim_fire;
    logic group_blank;
    logic over_temp;
    logic recovered;
    logic any_first_tick;
    logic [6:0] func_bits;
    logic [23:0] open_all;
    logic [23:0] short_all;
    logic [2:0] first_ticks;

    pwm_group_if grp_if [led_driver_pkg::NUM_COLORS] ();

    function automatic logic [12:0] mode_limit(input logic [1:0] mode);
        unique case (mode)
            led_driver_pkg::MODE_8BIT: return led_driver_pkg::LIMIT_8BIT;
            led_driver_pkg::MODE_10BIT: return led_driver_pkg::LIMIT_10BIT;
            default: return led_driver_pkg::LIMIT_12BIT;
        endcase
    endfunction : mode_limit

    function automatic logic [14:0] scale(input logic [6:0] trim,
                                          input logic [7:0] bright);
        return {8'h00, trim} * {7'h00, bright};
    endfunction : scale

    assign pins = {i_short_sense, i_open_sense, i_color_pwm_clocks,
                   i_temp_recovered, i_over_temp, i_blank_n_input,
                   i_gray_latch_strobe, i_trim_port_serial_in,
                   i_trim_port_shift_clock};

    // A pin level is taken over only once the last two stages agree.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            filt_reg <= '0;
        end
        else
        begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg <= filt_next;
        end
    end

    assign filt_next = (sync2_reg & sync3_reg)
        | (filt_reg & (sync2_reg ^ sync3_reg));
    assign rise = filt_next & ~filt_reg;
    assign strobe_rise = rise[PIN_STROBE];
    assign trim_rise = rise[PIN_TRIM_CLK];
    assign over_temp = filt_reg[PIN_OVER];
    assign recovered = filt_reg[PIN_RECOVERED];
    assign func_bits = cfg_latch_reg[led_driver_pkg::FUNC_LSB +: 7]; // RULE_07
    assign group_blank = !filt_reg[PIN_BLANK_N] || int_blank_reg; // RULE_03
    assign trim_fire = trim_timer_reg == 24'h000001 && !trim_rise;

    // Link side runs on the gray port shift clock. The status word is
    // handed over by toggle; it is stable long before the load edge.
    always_ff @(posedge i_gray_port_shift_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            load_sync1_reg <= 1'b0;
            load_sync2_reg <= 1'b0;
            load_ack_reg <= 1'b0;
        end
        else
        begin
            load_sync1_reg <= load_tgl_reg;
            load_sync2_reg <= load_sync1_reg;
            load_ack_reg <= load_sync2_reg;
        end
    end

    always_ff @(posedge i_gray_port_shift_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            common_shift_reg <= '0;
            strobe_at_edge_reg <= 1'b0;
        end
        else
        begin
            strobe_at_edge_reg <= i_gray_latch_strobe; // RULE_24
            if (load_sync2_reg != load_ack_reg)
                common_shift_reg <= status_reg; // RULE_14
            else
                common_shift_reg <= {common_shift_reg[286:0],
                                     i_gray_port_serial_in}; // RULE_14
        end
    end

    assign o_gray_port_serial_out = common_shift_reg[287];

    // The shift register and the edge level are quiet while the strobe
    // rises, so the synchronised strobe qualifies them as a word.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            gray_latch_reg <= '0;
        else if (strobe_rise && !strobe_at_edge_reg)
            gray_latch_reg <= common_shift_reg; // RULE_09
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            cfg_latch_reg <= '0;
        else if (strobe_rise && strobe_at_edge_reg) // RULE_24
            cfg_latch_reg[led_driver_pkg::GRAY_CFG_MSB:0] <= // RULE_23 RULE_04
                common_shift_reg[led_driver_pkg::GRAY_CFG_MSB:0];
        else if (trim_fire)
            cfg_latch_reg <= trim_shift_reg; // RULE_01 RULE_12
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            trim_shift_reg <= '0;
        else if (strobe_rise && strobe_at_edge_reg)
            trim_shift_reg[215:led_driver_pkg::USER_LSB] <=
                common_shift_reg[215:led_driver_pkg::USER_LSB]; // RULE_24
        else if (trim_rise)
            trim_shift_reg <= {trim_shift_reg[214:0],
                               filt_reg[PIN_TRIM_DATA]};
    end

    // Each shift edge restarts the wait, so only the last one latches.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            trim_timer_reg <= 24'h000000;
        else if (trim_rise)
            trim_timer_reg <= TRIM_LOAD; // RULE_01
        else if (trim_timer_reg != 24'h000000)
            trim_timer_reg <= trim_timer_reg - 24'h000001;
    end

    // Status is built one cycle after a grayscale write so it already
    // sees that cycle's flags.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            status_pending_reg <= 1'b0;
            status_reg <= '0;
            load_tgl_reg <= 1'b0;
        end
        else
        begin
            status_pending_reg <= strobe_rise && !strobe_at_edge_reg;
            if (status_pending_reg)
            begin
                status_reg <= '0; // RULE_13 RULE_26
                status_reg[led_driver_pkg::STAT_OPEN_LSB +: 24] <= open_all;
                status_reg[led_driver_pkg::STAT_SHORT_LSB +: 24] <= short_all;
                status_reg[led_driver_pkg::STAT_THERMAL_BIT] <=
                    thermal_flag_reg;
                status_reg[led_driver_pkg::STAT_CFG_LSB +: 216] <=
                    cfg_latch_reg; // RULE_12
                load_tgl_reg <= !load_tgl_reg; // RULE_14
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            int_blank_reg <= 1'b0;
        else
            int_blank_reg <= strobe_rise && !strobe_at_edge_reg
                && func_bits[led_driver_pkg::FUNC_TRESET_BIT]; // RULE_21
    end

    // A new heat event wins over a clear in the same cycle.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            thermal_flag_reg <= 1'b0;
        else if (over_temp)
            thermal_flag_reg <= 1'b1; // RULE_18
        else if (strobe_rise && recovered)
            thermal_flag_reg <= 1'b0; // RULE_20
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            blank_seen_reg <= 1'b0;
        else if (over_temp)
            blank_seen_reg <= 1'b0;
        else if (group_blank)
            blank_seen_reg <= 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            thermal_off_reg <= 1'b0;
        else if (over_temp)
            thermal_off_reg <= 1'b1; // RULE_18
        else if (blank_seen_reg && recovered && any_first_tick)
            thermal_off_reg <= 1'b0; // RULE_19
    end

    genvar c, n;
    generate
        for (c = 0; c < led_driver_pkg::NUM_COLORS; c++)
        begin : g_color
            assign grp_if[c].tick = rise[PIN_PWM_LSB + c];
            assign grp_if[c].blank = group_blank;
            assign grp_if[c].force_off = thermal_off_reg;
            assign grp_if[c].auto_repeat =
                func_bits[led_driver_pkg::FUNC_AUTO_BIT]; // RULE_21
            assign grp_if[c].limit = mode_limit( // RULE_10 RULE_11
                func_bits[led_driver_pkg::FUNC_MODE_LSB +: 2]);
            assign grp_if[c].open_sense = filt_reg[PIN_OPEN_LSB + c*8 +: 8];
            assign grp_if[c].short_sense =
                filt_reg[PIN_SHORT_LSB + c*8 +: 8];
            assign o_output_on[c*8 +: 8] = grp_if[c].on;
            assign open_all[c*8 +: 8] = grp_if[c].open_flag;
            assign short_all[c*8 +: 8] = grp_if[c].short_flag;
            assign first_ticks[c] = grp_if[c].first_tick;
            for (n = 0; n < led_driver_pkg::OUTS_PER_COLOR; n++)
            begin : g_out
                assign grp_if[c].gray[n*12 +: 12] =
                    gray_latch_reg[(n*3 + c)*12 +: 12]; // RULE_09
            end
            led_pwm_group u_group (
                .i_clk(i_clk),
                .i_rstn(i_rstn),
                .bus(grp_if[c].group)
            );
        end
    endgenerate

    assign any_first_tick = |first_ticks;
    assign o_open_detect_flag = open_all;
    assign o_short_detect_flag = short_all;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            level_reg <= '0;
        else
        begin
            for (int k = 0; k < led_driver_pkg::NUM_OUTPUTS; k++)
            begin
                level_reg[k*15 +: 15] <= scale(
                    cfg_latch_reg[((k % 8)*3 + k / 8)*7 +: 7], // RULE_23
                    cfg_latch_reg[led_driver_pkg::BRIGHT_LSB
                                  + (k / 8)*8 +: 8]); // RULE_05 RULE_04
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_trim_range <= 1'b0;
            o_user_defined_bits <= '0;
            o_thermal_error_flag <= 1'b0;
        end
        else
        begin
            o_trim_range <= func_bits[led_driver_pkg::FUNC_RANGE_BIT];
            o_user_defined_bits <=
                cfg_latch_reg[led_driver_pkg::USER_LSB +: 17]; // RULE_12
            o_thermal_error_flag <= thermal_flag_reg;
        end
    end

    assign o_output_level = level_reg;

endmodule : led_driver_config_status_latches

// ---- verif/gray_ctl_model.sv ----
// Controller model that drives the gray and trim serial ports.
module gray_ctl_model (
    output logic o_sck = 1'b0,
    output logic o_sin = 1'b0,
    output logic o_lat = 1'b0,
    output logic o_tck = 1'b0,
    output logic o_tin = 1'b0,
    input wire logic i_so
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic edge1(input logic b);
        o_sin = b;
        #24 o_sck = 1'b1;
        #24 o_sck = 1'b0;
    endtask : edge1
    task automatic frame(input logic [287:0] d, input logic cfg,
                         output logic [287:0] st);
        for (int i = 287; i >= 0; i--)
        begin
            o_lat = (i == 0) && cfg;
            edge1(d[i]);
        end
        o_lat = 1'b0;
        o_sin = ~o_sin;
        // The short high at the last edge is below the filter width.
        #400 o_lat = 1'b1;
        #600 o_lat = 1'b0;
        #1000 edge1(~o_sin);
        edge1(~o_sin);
        for (int i = 287; i >= 0; i--)
        begin
            edge1(~o_sin);
            st[i] = i_so;
        end
        o_sin = ~o_sin;
    endtask : frame
    task automatic trim(input logic [215:0] d);
        for (int i = 215; i >= 0; i--)
        begin
            o_tin = d[i];
            #400 o_tck = 1'b1;
            #400 o_tck = 1'b0;
        end
        o_tin = ~o_tin;
    endtask : trim
endmodule : gray_ctl_model

// ---- verif/led_driver_config_status_latches_sva.sv ----
// Port checker bound to the LED driver latch block.
module led_driver_config_status_latches_sva #(
    parameter int unsigned TRIM_LATCH_CYCLES = 20
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_gray_latch_strobe,
    input wire logic i_trim_port_shift_clock,
    input wire logic [2:0] i_color_pwm_clocks,
    input wire logic i_blank_n_input,
    input wire logic i_over_temp,
    input wire logic [23:0] o_output_on,
    input wire logic [23:0] o_open_detect_flag,
    input wire logic [23:0] o_short_detect_flag,
    input wire logic o_thermal_error_flag,
    input wire logic [359:0] o_output_level,
    input wire logic [16:0] o_user_defined_bits
);
    localparam int TLC = TRIM_LATCH_CYCLES;
    int trim_idle;
    int since_lat;
    int since_tick;
    logic trim_win;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    always_ff @(posedge i_clk or negedge i_rstn)
        if (!i_rstn) trim_idle <= TLC + 100;
        else if ($rose(i_trim_port_shift_clock)) trim_idle <= 0;
        else if (trim_idle < TLC + 100) trim_idle <= trim_idle + 1;
    always_ff @(posedge i_clk or negedge i_rstn)
        if (!i_rstn) since_lat <= 15;
        else if (i_gray_latch_strobe) since_lat <= 0;
        else if (since_lat < 15) since_lat <= since_lat + 1;
    always_ff @(posedge i_clk or negedge i_rstn)
        if (!i_rstn) since_tick <= 15;
        else if (i_color_pwm_clocks != 3'h0) since_tick <= 0;
        else if (since_tick < 15) since_tick <= since_tick + 1;
    assign trim_win = trim_idle >= TLC && trim_idle <= TLC + 8;
    sequence blank_held;
        !i_blank_n_input [*8];
    endsequence
    sequence hot_held;
        i_over_temp [*8];
    endsequence
    AST_BLANK_OFF:
        assert property (blank_held |-> o_output_on == 24'h0)
        else $error("On.");
    AST_HOT_OFF:
        assert property (hot_held |->
            o_thermal_error_flag && o_output_on == 24'h0) else $error("Hot.");
    AST_FLAG_HOLD:
        assert property ($fell(o_thermal_error_flag) |-> since_lat < 10)
        else $error("Flag clear.");
    AST_USER_WHEN:
        assert property ($changed(o_user_defined_bits) |-> trim_win)
        else $error("User bits.");
    AST_LEVEL_WHEN:
        assert property ($changed(o_output_level) |->
            trim_win || since_lat < 10) else $error("Level.");
    AST_ON_TICK:
        assert property ((o_output_on & ~$past(o_output_on)) != 24'h0
            |-> since_tick < 6) else $error("On early.");
    AST_OPEN_HOLD:
        assert property ($changed(o_open_detect_flag) |-> since_tick < 6)
        else $error("Open flags.");
    AST_SHORT_HOLD:
        assert property ($changed(o_short_detect_flag) |-> since_tick < 6)
        else $error("Short flags.");
endmodule : led_driver_config_status_latches_sva

bind led_driver_config_status_latches led_driver_config_status_latches_sva #(
    .TRIM_LATCH_CYCLES(TRIM_LATCH_CYCLES)
) sva_u (.*);

// ---- verif/tb.sv ----
// Self-checking bench for the LED driver latch block.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TLC = 20;
    logic clk = 1'b0, rstn = 1'b0, blank_n = 1'b0, ot = 1'b0, rec = 1'b0;
    logic [2:0] tick = 3'h0;
    logic [23:0] os = 24'h0, ss = 24'h0, eo = 24'h0, es = 24'h0;
    logic sck, sin, lat, tck, tin, so, therm, rng;
    logic [23:0] on, fo, fs, mask;
    logic [359:0] lvl;
    logic [16:0] ud;
    logic [223:0] r;
    logic [215:0] cfg, cm;
    logic [287:0] gv, st;
    integer seed = 32'hed1b;
    int bad_count = 0, num_checks = 0, cyc = 0, lim;
    always #50 clk = ~clk;
    gray_ctl_model ctl_u (.o_sck(sck), .o_sin(sin), .o_lat(lat),
        .o_tck(tck), .o_tin(tin), .i_so(so));
    led_driver_config_status_latches #(.TRIM_LATCH_CYCLES(TLC)) dut_u (
        .i_clk(clk), .i_rstn(rstn), .i_gray_port_shift_clock(sck),
        .i_gray_port_serial_in(sin), .i_gray_latch_strobe(lat),
        .i_trim_port_shift_clock(tck), .i_trim_port_serial_in(tin),
        .i_color_pwm_clocks(tick), .i_blank_n_input(blank_n),
        .i_over_temp(ot), .i_temp_recovered(rec), .i_open_sense(os),
        .i_short_sense(ss), .o_gray_port_serial_out(so), .o_output_on(on),
        .o_open_detect_flag(fo), .o_short_detect_flag(fs),
        .o_thermal_error_flag(therm), .o_output_level(lvl),
        .o_trim_range(rng), .o_user_defined_bits(ud));
    function automatic logic [14:0] level(input logic [215:0] c, input int k);
        int t;
        t = ((k % 8) * 3 + k / 8) * 7;
        return c[t+:7] * c[168 + (k / 8) * 8 +: 8];
    endfunction : level
    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : step
    task automatic ticks(input int n);
        repeat (n)
        begin
            tick = 3'h7;
            step(4);
            tick = 3'h0;
            step(4);
        end
    endtask : ticks
    task automatic rnd();
        for (int i = 0; i < 7; i++) r[i*32+:32] = $random(seed);
    endtask : rnd
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    initial
    begin
        step(20);
        rstn = 1'b1;
        step(6);
        chk(on === 24'h0 && fo === 24'h0, "reset state");
        rnd();
        cfg = r[215:0] | (216'h1 << 199);
        ctl_u.trim(cfg);
        step(5);
        chk(ud === 17'h0, "trim latched early");
        step(TLC);
        chk(ud === cfg[215:199] && rng === cfg[192], "trim latch");
        rnd();
        cm = r[215:0];
        cm[196:195] = 2'h0;
        for (int j = 0; j < 2; j++)
        begin
            cm[194:193] = j ? led_driver_pkg::MODE_10BIT
                : led_driver_pkg::MODE_8BIT;
            lim = j ? 1024 : 256;
            ctl_u.frame({72'h0, cm}, 1'b1, st);
            step(4);
            chk(ud === cfg[215:199] && rng === cm[192], "gray cfg");
            for (int k = 0; k < 24; k++)
                chk(lvl[k*15+:15] === level(cm, k), "level");
            rnd();
            mask = r[23:0] | 24'h1;
            os = r[55:32];
            ss = r[87:64];
            for (int k = 0; k < 24; k++)
                gv[((k % 8) * 3 + k / 8) * 12 +: 12] = {12{mask[k]}};
            ctl_u.frame(gv, 1'b0, st);
            chk(st[287:72] === {cfg[215:199], cm[198:0]}, "st");
            chk(st[71:0] === {24'h0, es, eo}, "status flags");
            step(1);
            blank_n = 1'b1;
            step(8);
            for (int t = 1; t <= lim; t++)
            begin
                ticks(1);
                if (t == 1) chk({on[5], on[0]} === 2'h1, "lag");
                if (t == 2) chk(on[5] === mask[5], "pair one");
                if (t == 32) chk(fo === eo && fs === es, "held");
                if (t == 33) chk(fo === (os & mask), "op");
                if (t == 33) chk(fs === (ss & mask), "short");
                if (t == lim - 1) chk(on[0] === 1'b1, "on at end");
                if (t == lim) chk(on[0] === 1'b0, "cut");
            end
            eo = os & mask;
            es = ss & mask;
            blank_n = 1'b0;
            step(8);
            chk(on === 24'h0, "blank off");
        end
        blank_n = 1'b1;
        ticks(3);
        ot = 1'b1;
        step(8);
        chk(therm === 1'b1 && on === 24'h0, "hot");
        ot = 1'b0;
        rec = 1'b1;
        ticks(3);
        chk(therm === 1'b1 && on === 24'h0, "latched off");
        blank_n = 1'b0;
        step(8);
        blank_n = 1'b1;
        ticks(2);
        chk(on[0] === 1'b1 && therm === 1'b1, "resume");
        blank_n = 1'b0;
        ctl_u.frame(gv, 1'b0, st);
        step(4);
        chk(therm === 1'b0, "flag clear");
        give_verdict();
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            give_verdict();
        end
    end
endmodule : tb
